/* File: core/csp_protect_top.sv */
// Purpose: decision and timing logic of a 3 to 5 cell battery protector
// Assumes: comparator results and selector levels arrive asynchronously
// Notes:   registers reached over apb; one level interrupt
//
// What this block does
// - overcharge output asserts after one second delay
// - overdischarge delay is 3.64 ms per nF
// - overcharge releases when cell falls below release
// - overdischarge releases at or above release level
// - wire break drives the overcharge output
// - restored wire releases the overcharge output
// - wire-break test repeats at programmed interval
// - shorten input high cuts overcharge delay hundredfold
// - middle level: 4 ms overcharge, overdischarge hundredfold
// - both faults drive both outputs together
// - open-drain: pull low normal, release when detected
// - push-pull: drive low normal, high when detected
// - selectors choose 3, 4 or 5 monitored cells
// - overcharge release delay of 16 ms
// - overdischarge release delay of 1.2 ms
//
// Our own choices: register access over APB and the register addresses.
`timescale 1ns/1ps
`include "csp_params.svh"
module csp_protect_top #(
  parameter int unsigned OC_DELAY_US   = `CSP_OC_DELAY_US,
  parameter int unsigned OC_RELEASE_US = `CSP_OC_RELEASE_US,
  parameter int unsigned OD_RELEASE_US = `CSP_OD_RELEASE_US,
  parameter int unsigned US_PER_MS     = `CSP_US_PER_MS
) (
  input  wire logic                   pclk,
  input  wire logic                   presetn,
  input  wire logic                   clk_en,
  input  wire logic                   psel,
  input  wire logic                   penable,
  input  wire logic                   pwrite,
  input  wire logic [11:0]            paddr,
  input  wire logic [31:0]            pwdata,
  output logic [31:0]                 prdata,
  output logic                        pready,
  output logic                        pslverr,
  input  wire csp_pkg::csp_cell_cmp_t cell_cmp,
  input  wire logic                   cell_count_select_a,
  input  wire logic                   cell_count_select_b,
  input  wire logic [1:0]             delay_shorten_in,
  output logic                        overcharge_out,
  output logic                        overcharge_oe,
  output logic                        overdischarge_out,
  output logic                        overdischarge_oe,
  output logic                        wirebreak_test_pulse,
  output logic                        irq
);
  import csp_pkg::*;

  // tick length in clocks, width of the synchroniser word
  localparam int unsigned TICK_CYCLES = `CSP_TICK_NS / `CSP_CLK_PERIOD_NS;
  localparam int unsigned SYNC_W      = $bits(csp_cell_cmp_t) + 4;

  // input synchronisers
  logic [SYNC_W-1:0] sync_meta;
  logic [SYNC_W-1:0] sync_q;
  csp_cell_cmp_t     cmp_s;
  logic [1:0]        sel_s;
  logic [1:0]        ds_s;

  // timing and channel state
  logic [5:0]        tick_div;
  logic              tick;
  logic [4:0]        cell_mask;
  logic [27:0]       oc_assert_limit;
  logic [27:0]       od_assert_limit;
  logic              oc_trip;
  logic              oc_clear;
  logic              od_trip;
  logic              od_clear;
  logic              oc_detected;
  logic              od_detected;
  logic [31:0]       wb_count;
  logic [31:0]       wb_limit;
  logic              wb_fault;
  logic              cout_active;
  logic              cout_prev;
  logic              od_prev;

  // registers
  logic [1:0]        ctrl;
  logic [15:0]       od_cap_nf;
  logic [15:0]       wb_interval_ms;
  logic [`CSP_IRQ_WIDTH-1:0] irq_status;
  logic [`CSP_IRQ_WIDTH-1:0] irq_enable;
  logic [`CSP_IRQ_WIDTH-1:0] irq_event;
  logic [`CSP_IRQ_WIDTH-1:0] clear_bits;
  logic              wr_en;
  logic [31:0]       next_prdata;
  logic              next_pslverr;

  // two flops on every pin-side input before any logic reads it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync_meta <= '0;
      sync_q    <= '0;
    end else if (clk_en) begin
      sync_meta <= {cell_cmp, cell_count_select_a, cell_count_select_b,
                    delay_shorten_in};
      sync_q    <= sync_meta;
    end
  end

  // unpack in the order the word was packed
  assign cmp_s = sync_q[SYNC_W-1:4];
  assign sel_s = sync_q[3:2];
  assign ds_s  = sync_q[1:0];

  // microsecond tick stands in for the internal oscillator
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tick_div <= 6'h00;
      tick     <= 1'b0;
    end else if (clk_en) begin
      // one-clock pulse per tick period
      if (tick_div == 6'(TICK_CYCLES - 1)) begin
        tick_div <= 6'h00;
        tick     <= 1'b1;
      end else begin
        tick_div <= tick_div + 6'h01;
        tick     <= 1'b0;
      end
    end
  end

  // cell count selection; unknown codes fall to five cells
  always_comb begin
    case (sel_s)
      `CSP_SEL_CODE_3CELL: cell_mask = `CSP_MASK_3CELL;
      `CSP_SEL_CODE_4CELL: cell_mask = `CSP_MASK_4CELL;
      default:             cell_mask = `CSP_MASK_5CELL;
    endcase
  end

  // assert delays depend on the three-level shorten input
  always_comb begin
    case (ds_s)
      `CSP_DS_LOW: begin
        oc_assert_limit = 28'(OC_DELAY_US);
        od_assert_limit = 28'(od_cap_nf * `CSP_OD_US_PER_NF);
      end
      `CSP_DS_MID: begin
        oc_assert_limit = 28'(`CSP_OC_MID_US);
        od_assert_limit = 28'(od_cap_nf * `CSP_OD_US_PER_NF_MID);
      end
      // supply level: overcharge cut, overdischarge unchanged
      default: begin
        oc_assert_limit = 28'(OC_DELAY_US / `CSP_OC_FAST_DIV);
        od_assert_limit = 28'(od_cap_nf * `CSP_OD_US_PER_NF);
      end
    endcase
  end

  // only selected cells count toward trip and release
  assign oc_trip  = |(cmp_s.oc_high & cell_mask);
  assign oc_clear = &(cmp_s.oc_rel_low | ~cell_mask);
  assign od_trip  = |(cmp_s.od_low & cell_mask);
  assign od_clear = &(cmp_s.od_rel_high | ~cell_mask);

  // overcharge channel: fixed delay, 16 ms release
  csp_fault_channel u_oc_channel (
    .pclk          (pclk),
    .presetn       (presetn),
    .clk_en        (clk_en),
    .tick          (tick),
    .trip          (oc_trip),
    .clear         (oc_clear),
    .assert_limit  (oc_assert_limit),
    .release_limit (28'(OC_RELEASE_US)),
    .detected      (oc_detected)
  );

  // overdischarge channel: capacitor-scaled delay, 1.2 ms release
  csp_fault_channel u_od_channel (
    .pclk          (pclk),
    .presetn       (presetn),
    .clk_en        (clk_en),
    .tick          (tick),
    .trip          (od_trip),
    .clear         (od_clear),
    .assert_limit  (od_assert_limit),
    .release_limit (28'(OD_RELEASE_US)),
    .detected      (od_detected)
  );

  // test interval in ticks
  assign wb_limit = 32'(wb_interval_ms) * 32'(US_PER_MS);

  // periodic wire-break test; the result holds until the next test,
  // so a restored wire releases at the following interval only
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wb_count             <= 32'h00000000;
      wb_fault             <= 1'b0;
      wirebreak_test_pulse <= 1'b0;
    end else if (clk_en) begin
      wirebreak_test_pulse <= 1'b0;
      // a disabled test also drops a held fault
      if (!ctrl[`CSP_CTRL_WB_ENABLE]) begin
        wb_count <= 32'h00000000;
        wb_fault <= 1'b0;
      end else if (tick) begin
        if (wb_count + 32'h00000001 >= wb_limit) begin
          wb_count             <= 32'h00000000;
          wirebreak_test_pulse <= 1'b1;
          wb_fault <= |(cmp_s.wire_open & cell_mask);
        end else begin
          wb_count <= wb_count + 32'h00000001;
        end
      end
    end
  end

  // overcharge output is shared with the wire-break fault
  assign cout_active = oc_detected | wb_fault;

  // pins straight from flops; channels are independent so both
  // outputs may be in the detected state at once
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      overcharge_out    <= 1'b0;
      overcharge_oe     <= 1'b1;
      overdischarge_out <= 1'b0;
      overdischarge_oe  <= 1'b1;
    end else if (clk_en) begin
      if (ctrl[`CSP_CTRL_PUSH_PULL]) begin
        // push-pull: low when normal, high when detected
        overcharge_out    <= cout_active;
        overcharge_oe     <= 1'b1;
        overdischarge_out <= od_detected;
        overdischarge_oe  <= 1'b1;
      end else begin
        // open-drain: pull low when normal, float when detected
        overcharge_out    <= 1'b0;
        overcharge_oe     <= ~cout_active;
        overdischarge_out <= 1'b0;
        overdischarge_oe  <= ~od_detected;
      end
    end
  end

  // edge memory for interrupt events
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cout_prev <= 1'b0;
      od_prev   <= 1'b0;
    end else if (clk_en) begin
      cout_prev <= oc_detected;
      od_prev   <= od_detected;
    end
  end

  // one-cycle events; release edges are reported too
  always_comb begin
    irq_event = '0;
    irq_event[`CSP_IRQ_OC_SET] = oc_detected & ~cout_prev;
    irq_event[`CSP_IRQ_OD_SET] = od_detected & ~od_prev;
    irq_event[`CSP_IRQ_WB_SET] = wirebreak_test_pulse & wb_fault;
    irq_event[`CSP_IRQ_OC_REL] = ~oc_detected & cout_prev;
    irq_event[`CSP_IRQ_OD_REL] = ~od_detected & od_prev;
  end

  // apb write strobe, at the completing access edge only
  assign wr_en = psel & penable & pready & pwrite;
  assign clear_bits = (wr_en && paddr == `CSP_ADDR_IRQ_CLEAR) ?
                      pwdata[`CSP_IRQ_WIDTH-1:0] : '0;

  // sticky status: a new event wins over a clear in the same cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_status <= '0;
      irq        <= 1'b0;
    end else if (clk_en) begin
      irq_status <= (irq_status & ~clear_bits) | irq_event;
      irq        <= |(irq_status & irq_enable);
    end
  end

  // writable registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl           <= `CSP_RST_CTRL;
      od_cap_nf      <= `CSP_RST_OD_CAP;
      wb_interval_ms <= `CSP_RST_WB_INTERVAL;
      irq_enable     <= '0;
    end else if (clk_en && wr_en) begin
      case (paddr)
        `CSP_ADDR_CTRL:        ctrl           <= pwdata[1:0];
        `CSP_ADDR_OD_CAP:      od_cap_nf      <= pwdata[15:0];
        `CSP_ADDR_WB_INTERVAL: wb_interval_ms <= pwdata[15:0];
        `CSP_ADDR_IRQ_ENABLE:
          irq_enable <= pwdata[`CSP_IRQ_WIDTH-1:0];
        default: begin
          // read-only and unmapped offsets keep their value
        end
      endcase
    end
  end

  // read mux, sampled during the setup cycle
  always_comb begin
    next_prdata  = 32'h00000000;
    next_pslverr = 1'b0;
    case (paddr)
      `CSP_ADDR_CTRL:        next_prdata[1:0]  = ctrl;
      `CSP_ADDR_OD_CAP:      next_prdata[15:0] = od_cap_nf;
      `CSP_ADDR_WB_INTERVAL: next_prdata[15:0] = wb_interval_ms;
      `CSP_ADDR_STATUS:
        next_prdata[12:0] = {cell_mask, ds_s, wb_fault, od_detected,
                             oc_detected, od_trip, oc_trip, 1'b0};
      `CSP_ADDR_IRQ_STATUS:
        next_prdata[`CSP_IRQ_WIDTH-1:0] = irq_status;
      `CSP_ADDR_IRQ_ENABLE:
        next_prdata[`CSP_IRQ_WIDTH-1:0] = irq_enable;
      // the clear register is write-only
      `CSP_ADDR_IRQ_CLEAR:   next_prdata = 32'h00000000;
      default:               next_pslverr = 1'b1;
    endcase
  end

  // one wait-free access phase: ready rises the cycle after setup
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      prdata  <= 32'h00000000;
      pslverr <= 1'b0;
    end else if (clk_en) begin
      if (psel && !penable) begin
        pready  <= 1'b1;
        prdata  <= pwrite ? 32'h00000000 : next_prdata;
        pslverr <= next_pslverr;
      end else begin
        // prdata holds until the next setup
        pready  <= 1'b0;
        pslverr <= 1'b0;
      end
    end
  end

endmodule : csp_protect_top

/* File: core/csp_params.svh */
// Purpose: named constants for the cell stack protection logic
// Assumes: pclk at 40 MHz; delays counted in 1 us ticks
// Notes:   byte addresses of the apb register map
`ifndef CSP_PARAMS_SVH
`define CSP_PARAMS_SVH

// clock and tick timing
`define CSP_CLK_PERIOD_NS    25
`define CSP_TICK_NS          1000
`define CSP_US_PER_MS        1000

// detection and release delays, in microseconds
`define CSP_OC_DELAY_US      1000000
`define CSP_OC_FAST_DIV      100
`define CSP_OC_MID_US        4000
`define CSP_OC_RELEASE_US    16000
`define CSP_OD_US_PER_NF     3640
`define CSP_OD_US_PER_NF_MID 36
`define CSP_OD_RELEASE_US    1200

// cell count selector codes {select_a, select_b}
`define CSP_SEL_CODE_3CELL   2'h0
`define CSP_SEL_CODE_4CELL   2'h1
`define CSP_MASK_3CELL       5'h07
`define CSP_MASK_4CELL       5'h0F
`define CSP_MASK_5CELL       5'h1F

// delay shorten input level codes
`define CSP_DS_LOW           2'h0
`define CSP_DS_MID           2'h1

// register byte addresses
`define CSP_ADDR_CTRL        12'h000
`define CSP_ADDR_OD_CAP      12'h004
`define CSP_ADDR_WB_INTERVAL 12'h008
`define CSP_ADDR_STATUS      12'h00C
`define CSP_ADDR_IRQ_STATUS  12'h010
`define CSP_ADDR_IRQ_ENABLE  12'h014
`define CSP_ADDR_IRQ_CLEAR   12'h018

// reset values
`define CSP_RST_CTRL         2'h2
`define CSP_RST_OD_CAP       16'h014A
`define CSP_RST_WB_INTERVAL  16'h03E8

// field positions
`define CSP_CTRL_PUSH_PULL   0
`define CSP_CTRL_WB_ENABLE   1
`define CSP_IRQ_WIDTH        5
`define CSP_IRQ_OC_SET       0
`define CSP_IRQ_OD_SET       1
`define CSP_IRQ_WB_SET       2
`define CSP_IRQ_OC_REL       3
`define CSP_IRQ_OD_REL       4

`endif

/* File: core/csp_pkg.sv */
// Purpose: shared types of the cell stack protection logic
// Assumes: csp_params.svh holds all numbers
// Notes:   one-hot channel states
package csp_pkg;

  // per-cell comparator results, bit n is cell n+1
  typedef struct packed {
    logic [4:0] oc_high;      // above overcharge_threshold
    logic [4:0] oc_rel_low;   // below overcharge_release_level
    logic [4:0] od_low;       // below overdischarge_threshold
    logic [4:0] od_rel_high;  // at or above overdischarge_release_level
    logic [4:0] wire_open;    // wire-break test result
  } csp_cell_cmp_t;

  // fault channel states
  typedef enum logic [3:0] {
    CSP_CH_NORMAL  = 4'b0001,
    CSP_CH_PENDING = 4'b0010,
    CSP_CH_DETECT  = 4'b0100,
    CSP_CH_RELEASE = 4'b1000
  } csp_ch_state_t;

endpackage : csp_pkg

/* File: core/csp_fault_channel.sv */
// Purpose: one fault channel with assert and release delay timing
// Assumes: tick is a one-cycle pulse every microsecond
// Notes:   detected is high in the detect and release states
`timescale 1ns/1ps
module csp_fault_channel (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        clk_en,
  input  wire logic        tick,
  input  wire logic        trip,
  input  wire logic        clear,
  input  wire logic [27:0] assert_limit,
  input  wire logic [27:0] release_limit,
  output logic             detected
);
  import csp_pkg::*;

  csp_ch_state_t state;
  logic [27:0]   count;
  logic [27:0]   next_count;

  assign next_count = count + 28'h0000001;

  // pending and releasing both restart timing if their cause goes away
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= CSP_CH_NORMAL;
      count <= 28'h0000000;
    end else if (clk_en) begin
      case (state)
        CSP_CH_NORMAL: begin
          count <= 28'h0000000;
          if (trip) begin
            state <= CSP_CH_PENDING;
          end
        end
        CSP_CH_PENDING: begin
          if (!trip) begin
            state <= CSP_CH_NORMAL;
            count <= 28'h0000000;
          end else if (tick) begin
            if (next_count >= assert_limit) begin
              state <= CSP_CH_DETECT;
              count <= 28'h0000000;
            end else begin
              count <= next_count;
            end
          end
        end
        CSP_CH_DETECT: begin
          count <= 28'h0000000;
          if (clear) begin
            state <= CSP_CH_RELEASE;
          end
        end
        CSP_CH_RELEASE: begin
          if (!clear) begin
            state <= CSP_CH_DETECT; // stays detected
            count <= 28'h0000000;
          end else if (tick) begin
            if (next_count >= release_limit) begin
              state <= CSP_CH_NORMAL;
              count <= 28'h0000000;
            end else begin
              count <= next_count;
            end
          end
        end
        default: begin
          state <= CSP_CH_NORMAL;
          count <= 28'h0000000;
        end
      endcase
    end
  end

  assign detected = (state == CSP_CH_DETECT) || (state == CSP_CH_RELEASE);

endmodule : csp_fault_channel

/* File: bench/csp_protect_checker.sv */
// Purpose: timing and pin assertions at the protector top ports
// Assumes: 40 cycles to a microsecond tick
// Notes:   run counters give lower bounds on assert and release delays
`timescale 1ns/1ps
`include "csp_params.svh"
module csp_protect_checker #(
  parameter int unsigned OC_DELAY_US   = `CSP_OC_DELAY_US,
  parameter int unsigned OC_RELEASE_US = `CSP_OC_RELEASE_US,
  parameter int unsigned OD_RELEASE_US = `CSP_OD_RELEASE_US
) (
  input wire logic                   pclk,
  input wire logic                   presetn,
  input wire logic                   pready,
  input wire csp_pkg::csp_cell_cmp_t cell_cmp,
  input wire logic                   cell_count_select_a,
  input wire logic                   cell_count_select_b,
  input wire logic                   overcharge_out,
  input wire logic                   overcharge_oe,
  input wire logic                   overdischarge_out,
  input wire logic                   overdischarge_oe,
  input wire logic                   wirebreak_test_pulse
);
  import csp_pkg::*;
  // one tick of jitter plus sync lag taken off every bound
  localparam int TK      = `CSP_TICK_NS / `CSP_CLK_PERIOD_NS;
  localparam int OC_MIN  = (OC_DELAY_US / `CSP_OC_FAST_DIV) * TK - 45;
  localparam int OD_MIN  = `CSP_OD_US_PER_NF_MID * TK - 45;
  localparam int OCR_MIN = OC_RELEASE_US * TK - 45;
  localparam int ODR_MIN = OD_RELEASE_US * TK - 45;
  logic [4:0]  mask;
  logic        oc_det;
  logic        od_det;
  logic [31:0] oc_run;
  logic [31:0] od_run;
  logic [31:0] ocr_run;
  logic [31:0] odr_run;
  // selected cells, raw selector levels
  always_comb begin
    case ({cell_count_select_a, cell_count_select_b})
      `CSP_SEL_CODE_3CELL: mask = `CSP_MASK_3CELL;
      `CSP_SEL_CODE_4CELL: mask = `CSP_MASK_4CELL;
      default:             mask = `CSP_MASK_5CELL;
    endcase
  end
  // detected in either output style
  assign oc_det = overcharge_out | ~overcharge_oe;
  assign od_det = overdischarge_out | ~overdischarge_oe;
  // consecutive cycles that each condition has held
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      oc_run  <= '0;
      od_run  <= '0;
      ocr_run <= '0;
      odr_run <= '0;
    end else begin
      oc_run  <= |(cell_cmp.oc_high & mask) ? oc_run + 1 : '0;
      od_run  <= |(cell_cmp.od_low & mask) ? od_run + 1 : '0;
      ocr_run <= &(cell_cmp.oc_rel_low | ~mask) ? ocr_run + 1 : '0;
      odr_run <= &(cell_cmp.od_rel_high | ~mask) ? odr_run + 1 : '0;
    end
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  chk_oc_assert_delay:
    assert property ($rose(oc_det) && !(|cell_cmp.wire_open)
      |-> oc_run >= OC_MIN) else $error("overcharge asserted early");
  chk_od_assert_delay:
    assert property ($rose(od_det) |-> od_run >= OD_MIN)
      else $error("overdischarge asserted early");
  chk_oc_release_delay:
    assert property ($fell(oc_det) |-> ocr_run >= OCR_MIN)
      else $error("overcharge released early");
  chk_od_release_delay:
    assert property ($fell(od_det) |-> odr_run >= ODR_MIN)
      else $error("overdischarge released early");
  chk_wire_fault_out:
    assert property (wirebreak_test_pulse && |(cell_cmp.wire_open & mask)
      && $past(|(cell_cmp.wire_open & mask), 3) |-> ##[1:4] oc_det)
      else $error("wire break not shown");
  chk_wire_pulse_gap:
    assert property (wirebreak_test_pulse |=> (!wirebreak_test_pulse) [*8])
      else $error("test pulse too long");
  chk_oc_pin_style:
    assert property (overcharge_out |-> overcharge_oe)
      else $error("overcharge high while undriven");
  chk_od_pin_style:
    assert property (overdischarge_out |-> overdischarge_oe)
      else $error("overdischarge high while undriven");
  chk_ready_one_cycle:
    assert property (pready |=> !pready) else $error("pready too long");
  // main scenarios reached
  cover property ($rose(oc_det));
  cover property ($rose(od_det));
  cover property (oc_det && od_det);
endmodule : csp_protect_checker

bind csp_protect_top csp_protect_checker #(
  .OC_DELAY_US(OC_DELAY_US), .OC_RELEASE_US(OC_RELEASE_US),
  .OD_RELEASE_US(OD_RELEASE_US)) u_chk (
  .pclk(pclk), .presetn(presetn), .pready(pready), .cell_cmp(cell_cmp),
  .cell_count_select_a(cell_count_select_a),
  .cell_count_select_b(cell_count_select_b),
  .overcharge_out(overcharge_out), .overcharge_oe(overcharge_oe),
  .overdischarge_out(overdischarge_out),
  .overdischarge_oe(overdischarge_oe),
  .wirebreak_test_pulse(wirebreak_test_pulse));

/* File: bench/csp_stack_model.sv */
// Purpose: comparator view of a five cell stack
// Assumes: two mode bits a cell: 0 normal 1 over 2 under 3 wire open
// Notes:   a broken wire keeps normal readings; only the test sees it
`timescale 1ns/1ps
module csp_stack_model (
  input  wire logic             pclk,
  input  wire logic [9:0]       cell_mode,
  output csp_pkg::csp_cell_cmp_t cell_cmp
);
  import csp_pkg::*;
  // all cells normal before the first edge
  initial cell_cmp = {5'h00, 5'h1F, 5'h00, 5'h1F, 5'h00};
  // comparator outputs move only just after a clock edge
  always @(posedge pclk) begin
    for (int i = 0; i < 5; i++) begin
      cell_cmp.oc_high[i]     <= cell_mode[2*i+:2] == 2'h1;
      cell_cmp.oc_rel_low[i]  <= cell_mode[2*i+:2] != 2'h1;
      cell_cmp.od_low[i]      <= cell_mode[2*i+:2] == 2'h2;
      cell_cmp.od_rel_high[i] <= cell_mode[2*i+:2] != 2'h2;
      cell_cmp.wire_open[i]   <= cell_mode[2*i+:2] == 2'h3;
    end
  end
endmodule : csp_stack_model

/* File: bench/tb_cell_stack_protection_logic.sv */
// Purpose: self-checking bench for the cell stack protector
// Assumes: shortened delays, 40 cycles a tick, 10 ticks a ms
// Notes:   delay windows allow one tick of jitter plus sync lag
`timescale 1ns/1ps
`include "csp_params.svh"
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin num_errors++; \
  $display("wrong value t=%0t got %0h exp %0h", $time, g, e); end end
module tb_cell_stack_protection_logic;
  import csp_pkg::*;
  localparam int TK     = 40;
  localparam int OC_LOW = 500 * TK;
  localparam int OC_HI  = 5 * TK;
  localparam int OD_MID = `CSP_OD_US_PER_NF_MID * TK;
  localparam int OC_REL = 20 * TK;
  localparam int OD_REL = 10 * TK;
  localparam int WB_PER = 20 * TK;
  logic          pclk = 0, presetn = 0, psel = 0, penable = 0;
  logic          pwrite = 0, pready, pslverr, err, sel_a = 0, sel_b = 0;
  logic [11:0]   paddr = '0;
  logic [31:0]   pwdata = '0, prdata, rd;
  logic          oc_out, oc_oe, od_out, od_oe, wb_pulse, irq;
  logic [1:0]    ds = 2'h0;
  logic          ce = 1'b1;
  logic [9:0]    mode = '0;
  csp_cell_cmp_t cmp;
  int            num_errors = 0, n_checks = 0, n;
  wire           oc_det = oc_out | ~oc_oe;
  wire           od_det = od_out | ~od_oe;
  always #12.5 pclk = ~pclk;
  csp_stack_model u_stack (.pclk(pclk), .cell_mode(mode), .cell_cmp(cmp));
  csp_protect_top #(.OC_DELAY_US(500), .OC_RELEASE_US(20),
    .OD_RELEASE_US(10), .US_PER_MS(10)) dut (
    .pclk(pclk), .presetn(presetn), .clk_en(ce), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .cell_cmp(cmp),
    .cell_count_select_a(sel_a), .cell_count_select_b(sel_b),
    .delay_shorten_in(ds), .overcharge_out(oc_out), .overcharge_oe(oc_oe),
    .overdischarge_out(od_out), .overdischarge_oe(od_oe),
    .wirebreak_test_pulse(wb_pulse), .irq(irq));
  // one apb transfer; an idle edge after it so psel is never set twice
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb
  task automatic rdc(input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    `CHK(rd, e)
  endtask : rdc
  // cycles until a detect flag reaches val, against a window
  task automatic wt(input logic od, input logic val, input int lo, hi);
    n = 0;
    while ((od ? od_det : oc_det) !== val && n < hi + 50) begin
      @(posedge pclk);
      n++;
    end
    `CHK(n >= lo && n <= hi, 1'b1)
  endtask : wt
  task automatic test_done;
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : test_done
  // hang guard, about two and a half times the expected run
  initial begin
    repeat (80000) @(posedge pclk);
    num_errors++;
    test_done();
  end
  initial begin
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    `CHK({oc_out, oc_oe, od_out, od_oe, irq}, 5'h0A)
    rdc(`CSP_ADDR_CTRL, 32'h2);
    rdc(`CSP_ADDR_OD_CAP, 32'h14A);
    rdc(`CSP_ADDR_WB_INTERVAL, 32'h3E8);
    rdc(`CSP_ADDR_IRQ_ENABLE, 32'h0);
    rdc(12'h01C, 32'h0);
    `CHK(err, 1'b1)
    apb(1'b1, `CSP_ADDR_OD_CAP, 32'h1);
    apb(1'b1, `CSP_ADDR_WB_INTERVAL, 32'h2);
    apb(1'b1, `CSP_ADDR_IRQ_ENABLE, 32'h1F);
    // full delay, release, then irq mask and clear
    mode <= 10'h001;
    wt(1'b0, 1'b1, OC_LOW - 45, OC_LOW + 45);
    mode <= 10'h000;
    wt(1'b0, 1'b0, OC_REL - 45, OC_REL + 45);
    rdc(`CSP_ADDR_IRQ_STATUS, 32'h9);
    `CHK(irq, 1'b1)
    apb(1'b1, `CSP_ADDR_IRQ_ENABLE, 32'h0);
    @(posedge pclk);
    `CHK(irq, 1'b0)
    apb(1'b1, `CSP_ADDR_IRQ_ENABLE, 32'h1F);
    apb(1'b1, `CSP_ADDR_IRQ_CLEAR, 32'h1F);
    rdc(`CSP_ADDR_IRQ_STATUS, 32'h0);
    `CHK(irq, 1'b0)
    // short trip is abandoned, a held one detects at the fast delay
    ds <= 2'h2;
    mode <= 10'h001;
    repeat (OC_HI - 80) @(posedge pclk);
    mode <= 10'h000;
    repeat (OC_HI * 2) @(posedge pclk);
    `CHK(oc_det, 1'b0)
    // frozen clock enable: a held trip goes unseen
    ce <= 1'b0;
    mode <= 10'h001;
    repeat (OC_HI * 2) @(posedge pclk);
    `CHK(oc_det, 1'b0)
    ce <= 1'b1;
    wt(1'b0, 1'b1, OC_HI - 45, OC_HI + 45);
    // second cell under while the first stays over
    ds <= 2'h1;
    mode <= 10'h009;
    wt(1'b1, 1'b1, OD_MID - 45, OD_MID + 45);
    `CHK({oc_out, oc_oe, od_out, od_oe}, 4'h0)
    rdc(`CSP_ADDR_STATUS, 32'h75E);
    apb(1'b1, `CSP_ADDR_CTRL, 32'h3);
    @(posedge pclk);
    `CHK({oc_out, oc_oe, od_out, od_oe}, 4'hF)
    mode <= 10'h001;
    wt(1'b1, 1'b0, OD_REL - 45, OD_REL + 45);
    mode <= 10'h000;
    wt(1'b0, 1'b0, OC_REL - 45, OC_REL + 45);
    `CHK({oc_out, oc_oe, od_out, od_oe}, 4'h5)
    apb(1'b1, `CSP_ADDR_CTRL, 32'h2);
    // a cell outside the selection is ignored until selected
    ds <= 2'h2;
    for (int k = 0; k < 2; k++) begin
      mode <= 10'h040 << (2 * k);
      repeat (OC_HI * 3) @(posedge pclk);
      `CHK(oc_det, 1'b0)
      {sel_a, sel_b} <= k ? 2'h2 : 2'h1;
      wt(1'b0, 1'b1, OC_HI - 45, OC_HI + 45);
      mode <= 10'h000;
      wt(1'b0, 1'b0, OC_REL - 45, OC_REL + 45);
    end
    // broken wire shows at a test, tests repeat, restore clears
    mode <= 10'h030;
    wt(1'b0, 1'b1, 0, WB_PER + 45);
    while (wb_pulse !== 1'b1) @(posedge pclk);
    @(posedge pclk);
    n = 1;
    while (wb_pulse !== 1'b1 && n < 2 * WB_PER) begin
      @(posedge pclk);
      n++;
    end
    `CHK(n >= WB_PER - 45 && n <= WB_PER + 45, 1'b1)
    mode <= 10'h000;
    wt(1'b0, 1'b0, 0, WB_PER + 45);
    rdc(`CSP_ADDR_IRQ_STATUS, 32'h1F);
    test_done();
  end
endmodule : tb_cell_stack_protection_logic
